// [logic/lcs_compositor.sv]
// Purpose: combines three display layers per byte, applies flash attributes and pixel scroll
// Assumes: scan bytes come from logic on core_clk_i; host steps the scroll registers
// Notes: output byte follows each scan strobe by one cycle
//
// Summary of operation
// RQ1 - shift whole image right by 0..7 pixels from scroll register bits 2-0
// RQ2 - host steps offset, wraps seven to zero and advances block start address
// RQ3 - host stops or fixes content at the virtual screen edge
// RQ4 - one offset applies to the combined image of all layers
// RQ5 - at 2 or 4 bits per pixel the pixel offset is forced to zero
// RQ6 - inverse, half-tone and flash come only from attribute and combine registers
// RQ7 - combine select 01 merges layers by exclusive-OR for inverse display
// RQ8 - combine select 00 merges layers by OR
// RQ9 - attribute bits 2 and 4 set, 3 and 5 clear: layers one, two steady on
// RQ10 - per-layer flash at 17 Hz gives apparent half intensity
// RQ11 - attribute 34h: layer one steady, layer two flashes at 17 Hz
// RQ12 - per-layer 2 Hz flash lets an OR-combined block flash alone
// RQ13 - host flashes small areas by rewriting codes every half to one second
// RQ14 - each pixel combines enabled layer bits; off or dark layers give zero
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module lcs_compositor #(
  parameter int FAST_HALF = lcs_pkg::LCS_FAST_HALF, // cycles per 17 Hz half period
  parameter int SLOW_HALF = lcs_pkg::LCS_SLOW_HALF  // cycles per 2 Hz half period
) (
  input wire logic core_clk_i,                 // 250 MHz core clock
  input wire logic reset_i,                    // async reset, active high
  input wire lcs_pkg::lcs_reg_req_t reg_req_i, // register port request
  output logic [7:0] reg_rdata_o,              // read data, cycle after read strobe
  input wire lcs_pkg::lcs_scan_t scan_i,       // layer bytes from display scan
  output lcs_pkg::lcs_pix_t pix_o              // combined, scrolled pixel byte
);
  import lcs_pkg::*;

  logic [7:0] attr;
  logic [7:0] combine;
  logic [7:0] hscroll;
  logic [7:0] mode;
  logic [LCS_CNT_W-1:0] fast_cnt;
  logic [LCS_CNT_W-1:0] slow_cnt;
  logic fast_phase;
  logic slow_phase;
  logic [7:0] prev_byte;
  logic [LCS_SCROLL_W-1:0] eff_off;
  logic [LCS_NUM_LAYERS-1:0] layer_vis;
  logic [LCS_NUM_LAYERS-1:0][7:0] masked;
  logic [7:0] next_comb;
  logic [15:0] pair;
  logic [7:0] status;

  // register writes
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      attr <= LCS_ATTR_RST;
      combine <= LCS_COMBINE_RST;
      hscroll <= LCS_HSCROLL_RST;
      mode <= LCS_MODE_RST;
    end else if (reg_req_i.wr) begin
      case (reg_req_i.addr)
        LCS_ADDR_ATTR: attr <= reg_req_i.wdata;       // [RQ6]
        LCS_ADDR_COMBINE: combine <= reg_req_i.wdata; // [RQ6]
        LCS_ADDR_HSCROLL: hscroll <= reg_req_i.wdata;
        LCS_ADDR_MODE: mode <= reg_req_i.wdata;
        default: ;
      endcase
    end
  end

  // status view of the block's own state
  assign status = {3'h0, eff_off, slow_phase, fast_phase};

  // register reads, unmapped addresses read as zero
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        LCS_ADDR_ATTR: reg_rdata_o <= attr;
        LCS_ADDR_COMBINE: reg_rdata_o <= combine;
        LCS_ADDR_HSCROLL: reg_rdata_o <= {5'h00, hscroll[LCS_SCROLL_W-1:0]};
        LCS_ADDR_MODE: reg_rdata_o <= {6'h00, mode[1:0]};
        LCS_ADDR_STATUS: reg_rdata_o <= status;
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // 17 Hz blink phase
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      fast_cnt <= '0;
      fast_phase <= 1'b0;
    end else if (fast_cnt == LCS_CNT_W'(FAST_HALF - 1)) begin
      fast_cnt <= '0;
      fast_phase <= ~fast_phase; // [RQ10]
    end else begin
      fast_cnt <= fast_cnt + 1'b1;
    end
  end

  // 2 Hz blink phase
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      slow_cnt <= '0;
      slow_phase <= 1'b0;
    end else if (slow_cnt == LCS_CNT_W'(SLOW_HALF - 1)) begin
      slow_cnt <= '0;
      slow_phase <= ~slow_phase; // [RQ12]
    end else begin
      slow_cnt <= slow_cnt + 1'b1;
    end
  end

  // per-layer visibility from its attribute field and the blink phases
  genvar g;
  generate
    for (g = 0; g < LCS_NUM_LAYERS; g++) begin : g_layer
      logic [1:0] fld;
      assign fld = attr[LCS_ATTR_LAYER_LSB + 2*g +: 2];
      always_comb begin
        case (fld)
          LCS_ATTR_ON: layer_vis[g] = 1'b1;         // [RQ9] [RQ11]
          LCS_ATTR_SLOW: layer_vis[g] = slow_phase; // [RQ12]
          LCS_ATTR_FAST: layer_vis[g] = fast_phase; // [RQ10] [RQ11]
          default: layer_vis[g] = 1'b0;
        endcase
      end
      assign masked[g] = layer_vis[g] ? scan_i.layer[g] : 8'h00; // [RQ14]
    end
  endgenerate

  // combine function over the masked layers
  always_comb begin
    case (combine[1:0])
      LCS_COMB_OR: next_comb = masked[0] | masked[1] | masked[2];  // [RQ8]
      LCS_COMB_XOR: next_comb = masked[0] ^ masked[1] ^ masked[2]; // [RQ7]
      LCS_COMB_AND: next_comb = masked[0] & masked[1] & masked[2];
      default: next_comb = masked[0] | masked[1] | masked[2];
    endcase
  end

  // pixel offset only at one bit per pixel
  assign eff_off = (mode[1:0] == LCS_BPP_1) ? hscroll[LCS_SCROLL_W-1:0] : '0; // [RQ1] [RQ5]
  // one shifter after combining, so every layer moves together
  assign pair = {prev_byte, next_comb} >> eff_off; // [RQ4]

  // carry of the previous combined byte, updated on every scan byte and ignored for a line's first byte
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      prev_byte <= 8'h00;
    end else if (scan_i.valid) begin
      prev_byte <= next_comb;
    end
  end

  // registered pixel output
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pix_o <= '0;
    end else begin
      pix_o.valid <= scan_i.valid;
      if (scan_i.valid) begin
        pix_o.data <= scan_i.first ? (next_comb >> eff_off) : pair[7:0]; // [RQ1]
      end
    end
  end

  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  logic steady_or;
  assign steady_or = (attr[7:2] == 6'b010101) && (combine[1:0] == LCS_COMB_OR);

  a_scroll_shift: assert property ( // [RQ1]
    scan_i.valid && !scan_i.first && steady_or && (mode[1:0] == LCS_BPP_1)
    ##1 scan_i.valid && !scan_i.first && steady_or && (mode[1:0] == LCS_BPP_1)
    && $stable(hscroll)
    |=> pix_o.data == 8'(({$past(scan_i.layer[0] | scan_i.layer[1] | scan_i.layer[2], 2),
      $past(scan_i.layer[0] | scan_i.layer[1] | scan_i.layer[2])} >> $past(hscroll[2:0]))))
    else $error("pixel offset not applied to combined image");
  a_bpp_noscroll: assert property ( // [RQ5]
    scan_i.valid && scan_i.first && (mode[1:0] != LCS_BPP_1) && steady_or
    |=> pix_o.data == $past(scan_i.layer[0] | scan_i.layer[1] | scan_i.layer[2]))
    else $error("pixel offset used at multi-bit depth");
  a_xor_inverse: assert property ( // [RQ7]
    scan_i.valid && scan_i.first && combine[1:0] == LCS_COMB_XOR && attr[7:2] == 6'b000101
    |=> pix_o.data == ($past(scan_i.layer[0] ^ scan_i.layer[1]) >> $past(eff_off)))
    else $error("exclusive-OR combine wrong");
  a_or_combine: assert property ( // [RQ8]
    scan_i.valid && scan_i.first && steady_or && eff_off == 3'h0
    |=> pix_o.data == $past(scan_i.layer[0] | scan_i.layer[1] | scan_i.layer[2]))
    else $error("OR combine wrong");
  a_menu_pad: assert property ( // [RQ11]
    scan_i.valid && scan_i.first && attr == 8'h34 && combine[1:0] == LCS_COMB_OR
    && eff_off == 3'h0
    |=> pix_o.data == $past(fast_phase ? (scan_i.layer[0] | scan_i.layer[1]) : scan_i.layer[0]))
    else $error("half-tone layer two wrong");
  a_fast_period: assert property ( // [RQ10]
    $changed(fast_phase) |-> $past(fast_cnt) == LCS_CNT_W'(FAST_HALF - 1))
    else $error("17 Hz phase toggled off schedule");
  a_slow_period: assert property ( // [RQ12]
    $changed(slow_phase) |-> $past(slow_cnt) == LCS_CNT_W'(SLOW_HALF - 1))
    else $error("2 Hz phase toggled off schedule");
  a_layers_off: assert property ( // [RQ14]
    scan_i.valid && scan_i.first && attr[7:2] == 6'h00 |=> pix_o.data == 8'h00)
    else $error("disabled layers produced pixels");
  a_attr_source: assert property ( // [RQ6]
    !(reg_req_i.wr && (reg_req_i.addr == LCS_ADDR_ATTR || reg_req_i.addr == LCS_ADDR_COMBINE))
    |=> $stable(attr) && $stable(combine))
    else $error("attribute state changed without a write");

  // OR of the raw scan bytes, used by the first-byte reference expression below
  logic [7:0] scan_or;
  assign scan_or = scan_i.layer[0] | scan_i.layer[1] | scan_i.layer[2];

  // output strobe tracks the scan strobe one cycle later
  a_pix_follow: assert property ( // [RQ14]
    scan_i.valid |=> pix_o.valid)
    else $error("pixel strobe missing after scan byte");
  a_pix_quiet: assert property ( // [RQ14]
    !scan_i.valid |=> !pix_o.valid)
    else $error("pixel strobe without scan byte");

  // the output byte holds between scan bytes
  a_pix_hold: assert property ( // [RQ14]
    !scan_i.valid |=> $stable(pix_o.data))
    else $error("pixel byte changed between scan bytes");

  // read data returns to zero outside the answer cycle
  a_rdata_idle: assert property ( // [RQ6]
    !reg_req_i.rd |=> reg_rdata_o == 8'h00)
    else $error("read data not idle");

  // attribute register reads back what is stored
  a_attr_readback: assert property ( // [RQ6]
    reg_req_i.rd && reg_req_i.addr == LCS_ADDR_ATTR
    |=> reg_rdata_o == $past(attr))
    else $error("attribute readback wrong");

  // scroll register reads back its three offset bits only
  a_scroll_readback: assert property ( // [RQ1]
    reg_req_i.rd && reg_req_i.addr == LCS_ADDR_HSCROLL
    |=> reg_rdata_o == {5'h00, $past(hscroll[2:0])})
    else $error("scroll readback wrong");

  // scroll write lands in the next cycle
  a_scroll_write: assert property ( // [RQ1]
    reg_req_i.wr && reg_req_i.addr == LCS_ADDR_HSCROLL
    |=> hscroll == $past(reg_req_i.wdata))
    else $error("scroll write lost");

  // combine write lands in the next cycle
  a_combine_write: assert property ( // [RQ7]
    reg_req_i.wr && reg_req_i.addr == LCS_ADDR_COMBINE
    |=> combine == $past(reg_req_i.wdata))
    else $error("combine write lost");

  // a line's first byte carries nothing in from the left
  a_first_shift: assert property ( // [RQ1] [RQ4]
    scan_i.valid && scan_i.first && steady_or && (mode[1:0] == LCS_BPP_1)
    |=> pix_o.data == ($past(scan_or) >> $past(hscroll[2:0])))
    else $error("first byte of line shifted wrongly");

  // exclusive-OR reaches the third layer as well
  a_xor_three: assert property ( // [RQ7]
    scan_i.valid && scan_i.first && combine[1:0] == LCS_COMB_XOR
    && attr[7:2] == 6'b010101 && eff_off == 3'h0
    |=> pix_o.data == $past(scan_i.layer[0] ^ scan_i.layer[1] ^ scan_i.layer[2]))
    else $error("three-layer exclusive-OR wrong");

  // a fast-flash layer is dark while its phase is low
  a_flash_dark: assert property ( // [RQ10]
    scan_i.valid && scan_i.first && attr[7:2] == 6'b001100 && !fast_phase
    |=> pix_o.data == 8'h00)
    else $error("flashing layer shown in dark phase");

  // slow flash of layer two over a steady layer one
  a_slow_block: assert property ( // [RQ12]
    scan_i.valid && scan_i.first && attr[7:2] == 6'b001001
    && combine[1:0] == LCS_COMB_OR && eff_off == 3'h0
    |=> pix_o.data == $past(slow_phase ? (scan_i.layer[0] | scan_i.layer[1]) : scan_i.layer[0]))
    else $error("2 Hz block flash wrong");

  // steady layers one and two, nothing from layer three
  a_two_steady: assert property ( // [RQ9]
    scan_i.valid && scan_i.first && attr[7:2] == 6'b000101
    && combine[1:0] == LCS_COMB_OR && eff_off == 3'h0
    |=> pix_o.data == $past(scan_i.layer[0] | scan_i.layer[1]))
    else $error("two steady layers wrong");

  c_xor_mode: cover property (scan_i.valid && combine[1:0] == LCS_COMB_XOR);
  c_scroll_seven: cover property (scan_i.valid && eff_off == 3'h7);
  c_fast_flash_on: cover property (scan_i.valid && attr == 8'h34 && fast_phase);
  c_slow_flash_on: cover property (scan_i.valid && attr == 8'h24 && slow_phase);
endmodule : lcs_compositor
`default_nettype wire

// [logic/lcs_pkg.sv]
// Purpose: shared constants and carriers for the layer compositor with pixel scroll
// Assumes: 250 MHz core clock, 8-bit register port, one byte per layer per scan strobe
// Notes: flash half periods are derived from the blink rates and the clock rate
package lcs_pkg;
  // register offsets
  localparam logic [7:0] LCS_ADDR_ATTR = 8'h0A;
  localparam logic [7:0] LCS_ADDR_COMBINE = 8'h18;
  localparam logic [7:0] LCS_ADDR_HSCROLL = 8'h1B;
  localparam logic [7:0] LCS_ADDR_MODE = 8'h30;
  localparam logic [7:0] LCS_ADDR_STATUS = 8'h31;
  // reset values
  localparam logic [7:0] LCS_ATTR_RST = 8'h00;
  localparam logic [7:0] LCS_COMBINE_RST = 8'h00;
  localparam logic [7:0] LCS_HSCROLL_RST = 8'h00;
  localparam logic [7:0] LCS_MODE_RST = 8'h00;
  // field positions
  localparam int LCS_ATTR_LAYER_LSB = 2;  // layer n field at [LSB+2n+1 : LSB+2n]
  localparam int LCS_SCROLL_W = 3;
  localparam int LCS_NUM_LAYERS = 3;
  // per-layer attribute codes
  localparam logic [1:0] LCS_ATTR_OFF = 2'b00;
  localparam logic [1:0] LCS_ATTR_ON = 2'b01;
  localparam logic [1:0] LCS_ATTR_SLOW = 2'b10;
  localparam logic [1:0] LCS_ATTR_FAST = 2'b11;
  // combine select codes
  localparam logic [1:0] LCS_COMB_OR = 2'b00;
  localparam logic [1:0] LCS_COMB_XOR = 2'b01;
  localparam logic [1:0] LCS_COMB_AND = 2'b10;
  // pixel depth codes in the mode register
  localparam logic [1:0] LCS_BPP_1 = 2'b00;
  // timing
  localparam longint LCS_CLK_HZ = 250_000_000;
  localparam longint LCS_FAST_HZ = 17;
  localparam longint LCS_SLOW_HZ = 2;
  localparam int LCS_FAST_HALF = int'(LCS_CLK_HZ / (2 * LCS_FAST_HZ));
  localparam int LCS_SLOW_HALF = int'(LCS_CLK_HZ / (2 * LCS_SLOW_HZ));
  localparam int LCS_CNT_W = 27;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lcs_reg_req_t;

  // one display byte per layer, msb is leftmost pixel
  typedef struct packed {
    logic valid;
    logic first;
    logic [LCS_NUM_LAYERS-1:0][7:0] layer;
  } lcs_scan_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } lcs_pix_t;
endpackage : lcs_pkg

// [verification/lcs_host_model.sv]
// Purpose: host model driving the compositor register port
// Assumes: strobes change right after the rising edge and last one cycle
// Notes: read data is taken in the cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module lcs_host_model
  import lcs_pkg::*;
(
  input wire logic core_clk_i,        // core clock
  input wire logic [7:0] rdata_i,     // read data from the block
  output var lcs_pkg::lcs_reg_req_t req_o // register request
);
  initial req_o = '0;
  // one-cycle write strobe beside address and data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk_i);
    req_o <= '0;
  endtask : wr
  // one-cycle read strobe, data picked up in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk_i);
    req_o <= '0;
    #1 d = rdata_i;
  endtask : rd
endmodule : lcs_host_model
`default_nettype wire

// [verification/tb_lcs_compositor.sv]
// Purpose: self-checking bench for the layer compositor
// Assumes: short flash half periods of 8 and 20 cycles
// Notes: a queue model predicts every output byte outside the flash counting runs
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_total++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_lcs_compositor;
  import lcs_pkg::*;
  localparam int FH = 8;
  localparam int SH = 20;
  logic core_clk_i, reset_i;
  logic [7:0] rdata, rv, prev_c, c, exp_v;
  lcs_reg_req_t req;
  lcs_scan_t scan;
  lcs_pix_t pix;
  int err_total, n_tests, ones, cnt_on, n;
  bit counting;
  logic [7:0] expq[$];
  lcs_host_model i_lcs_host_model (.core_clk_i(core_clk_i), .rdata_i(rdata), .req_o(req));
  lcs_compositor #(.FAST_HALF(FH), .SLOW_HALF(SH)) i_lcs_compositor (.core_clk_i(core_clk_i),
    .reset_i(reset_i), .reg_req_i(req), .reg_rdata_o(rdata), .scan_i(scan), .pix_o(pix));
  // model of the combine function, off layers give zero
  function automatic logic [7:0] comb_f(input logic [1:0] s, input logic [2:0] en,
                                        input logic [2:0][7:0] l);
    logic [7:0] v[3];
    for (int i = 0; i < 3; i++) v[i] = en[i] ? l[i] : 8'h00;
    case (s)
      2'b01: return v[0] ^ v[1] ^ v[2];
      2'b10: return v[0] & v[1] & v[2];
      default: return v[0] | v[1] | v[2];
    endcase
  endfunction : comb_f
  // queue the expected byte and present one scan byte
  task automatic send(input logic [2:0][7:0] l, input bit f, input logic [7:0] cv, input int o);
    expq.push_back(f ? 8'(cv >> o) : 8'({prev_c, cv} >> o));
    prev_c = cv;
    @(posedge core_clk_i);
    scan <= '{valid: 1'b1, first: f, layer: l};
  endtask : send
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  // output monitor, settled values at the falling edge
  always @(negedge core_clk_i) begin
    if (pix.valid === 1'b1) begin
      if (counting) begin
        ones += int'(pix.data === 8'hFF);
        cnt_on += int'(pix.data === 8'h0F);
      end else if (expq.size() > 0) begin
        exp_v = expq.pop_front();
        `CHK(pix.data, exp_v)
      end else `CHK(pix.valid, 1'b0)
    end
  end
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  // watchdog
  initial begin
    #400000;
    err_total++;
    close_out();
  end
  initial begin
    logic [2:0][7:0] l;
    logic [1:0] sel, md;
    logic [2:0] en;
    int off;
    reset_i = 1'b1;
    scan = '0;
    prev_c = 8'h00;
    counting = 1'b0;
    void'($urandom(32'h4FF4));
    repeat (5) @(posedge core_clk_i);
    reset_i <= 1'b0;
    i_lcs_host_model.rd(LCS_ADDR_COMBINE, rv);
    `CHK(rv, LCS_COMBINE_RST)
    i_lcs_host_model.wr(LCS_ADDR_HSCROLL, 8'hFF);
    i_lcs_host_model.rd(LCS_ADDR_HSCROLL, rv);
    `CHK(rv, 8'h07)
    i_lcs_host_model.wr(8'h40, 8'h5A);
    i_lcs_host_model.rd(8'h40, rv);
    `CHK(rv, 8'h00)
    // random layers, combine codes, depths; offset stepped and wrapped
    for (int i = 0; i < 48; i++) begin
      for (int k = 0; k < 3; k++) l[k] = 8'($urandom);
      sel = (i < 4) ? 2'(i) : (i < 8) ? LCS_COMB_OR : 2'($urandom);
      en = (i < 4) ? 3'b011 : (i < 8) ? 3'b111 : 3'($urandom);
      md = (i < 4 || i >= 8) ? 2'($urandom) : LCS_BPP_1;
      off = (md == LCS_BPP_1) ? i % 8 : 0;
      i_lcs_host_model.wr(LCS_ADDR_ATTR, {1'b0, en[2], 1'b0, en[1], 1'b0, en[0], 2'b00});
      i_lcs_host_model.wr(LCS_ADDR_COMBINE, {6'h00, sel});
      i_lcs_host_model.wr(LCS_ADDR_HSCROLL, 8'(i % 8));
      i_lcs_host_model.wr(LCS_ADDR_MODE, {6'h00, md});
      i_lcs_host_model.rd(LCS_ADDR_MODE, rv);
      `CHK(rv, {6'h00, md})
      c = comb_f(sel, en, l);
      send(l, 1'b1, c, off);
      l[0] = ~l[0];
      send(l, 1'b0, comb_f(sel, en, l), off);
      l[1] = ~l[1];
      send(l, 1'b0, comb_f(sel, en, l), off);
      @(posedge core_clk_i);
      scan.valid <= 1'b0;
    end
    // effective offset seen in status, then wrap the offset back to zero
    i_lcs_host_model.rd(LCS_ADDR_STATUS, rv);
    `CHK(rv[4:2], (md == LCS_BPP_1) ? 3'h7 : 3'h0)
    i_lcs_host_model.wr(LCS_ADDR_HSCROLL, 8'h00);
    // flashing second layer over steady first layer, 17 Hz then 2 Hz
    i_lcs_host_model.wr(LCS_ADDR_COMBINE, 8'h00);
    for (int k = 0; k < 2; k++) begin
      i_lcs_host_model.wr(LCS_ADDR_ATTR, k ? 8'h24 : 8'h34);
      n = k ? 4 * SH : 4 * FH;
      ones = 0;
      cnt_on = 0;
      counting = 1'b1;
      @(posedge core_clk_i);
      scan <= '{valid: 1'b1, first: 1'b1, layer: {8'h00, 8'hFF, 8'h0F}};
      repeat (n) @(posedge core_clk_i);
      scan.valid <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      counting = 1'b0;
      `CHK(ones, n / 2)
      `CHK(cnt_on, n / 2)
    end
    // small-area flash: host alternates a character code and a blank byte
    i_lcs_host_model.wr(LCS_ADDR_ATTR, 8'h04);
    for (int k = 0; k < 4; k++) begin
      l = '0;
      l[0] = k[0] ? 8'h00 : 8'($urandom);
      send(l, 1'b1, comb_f(LCS_COMB_OR, 3'b001, l), 0);
      @(posedge core_clk_i);
      scan.valid <= 1'b0;
    end
    repeat (3) @(posedge core_clk_i);
    `CHK(expq.size(), 0)
    close_out();
  end
endmodule : tb_lcs_compositor
`default_nettype wire
